// file: hdl/tk_defs.svh
// Purpose: Shared constants for the timekeeping memory block
// Assumes: 25 MHz system clock
// Notes:   Image bytes sit at the top eight byte addresses
`ifndef TK_DEFS_SVH
`define TK_DEFS_SVH

`define ADDR_W          19
`define DATA_W          8
`define MEM_DEPTH       524288
`define IMAGE_TAG       16'hFFFF
`define CTRL_ADDR       19'h7FFF8

// Image byte index, low three address bits
`define IDX_CTRL        3'h0
`define IDX_SECONDS     3'h1
`define IDX_MINUTES     3'h2
`define IDX_HOURS       3'h3
`define IDX_DAY         3'h4
`define IDX_DATE        3'h5
`define IDX_MONTH       3'h6
`define IDX_YEAR        3'h7

// Field positions
`define CTRL_WRITE_BIT  7
`define CTRL_READ_BIT   6
`define SEC_STOP_BIT    7

// Reset values: control cleared, calendar at year 00, Jan 01, day 1
`define IMAGE_RESET     64'h0001_0101_0000_0000
`define TIME_RESET      56'h00_01_01_01_00_00_00

// Timing
`define TICK_PERIOD_NS  1000000000
`define CLK_PERIOD_NS   40

`endif

// file: hdl/tk_pkg.sv
// Purpose: Types for the timekeeping memory block
// Assumes: No constants from tk_defs.svh; field widths are written as literals
// Notes:   Calendar fields are BCD bytes
package tk_pkg;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } cal_time_t;

    // Gray order along idle, read, write, abort
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_READ  = 2'b01,
        BUS_WRITE = 2'b11,
        BUS_ABORT = 2'b10
    } bus_state_t;

endpackage

// file: hdl/calendar_counter.sv
// Purpose: BCD calendar counters that keep the real time
// Assumes: tick_i is a one-cycle pulse once per second
// Notes:   Load has priority over the tick
`timescale 1ns/10ps
`default_nettype none
`include "tk_defs.svh"

module calendar_counter (
    input  wire logic             clk_sys_i,   // System clock
    input  wire logic             rst_n_i,     // Synchronised reset
    input  wire logic             tick_i,      // One-second pulse
    input  wire logic             load_i,      // Load counters
    input  wire tk_pkg::cal_time_t load_time_i, // Value to load
    output var  tk_pkg::cal_time_t time_o       // Current time
);
    import tk_pkg::*;

    cal_time_t time_reg;
    cal_time_t time_next;

    function automatic logic [7:0] bcd_next(input logic [7:0] v);
        bcd_next = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Years divisible by four, valid through 2099
    function automatic logic is_leap(input logic [7:0] y);
        is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02:   month_days = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default: month_days = 8'h31;
        endcase
    endfunction

    always_comb begin
        time_next = time_reg;
        if (load_i) begin
            time_next = load_time_i;
        end else if (tick_i) begin
            if (time_reg.seconds != 8'h59) begin
                time_next.seconds = bcd_next(time_reg.seconds);
            end else begin
                time_next.seconds = 8'h00;
                if (time_reg.minutes != 8'h59) begin
                    time_next.minutes = bcd_next(time_reg.minutes);
                end else begin
                    time_next.minutes = 8'h00;
                    if (time_reg.hours != 8'h23) begin
                        time_next.hours = bcd_next(time_reg.hours);
                    end else begin
                        time_next.hours = 8'h00;
                        time_next.day   = (time_reg.day == 8'h07) ? 8'h01 : bcd_next(time_reg.day);
                        if (time_reg.date != month_days(time_reg.month, time_reg.year)) begin
                            time_next.date = bcd_next(time_reg.date);
                        end else begin
                            time_next.date = 8'h01;
                            if (time_reg.month != 8'h12) begin
                                time_next.month = bcd_next(time_reg.month);
                            end else begin
                                time_next.month = 8'h01;
                                time_next.year  = (time_reg.year == 8'h99) ? 8'h00 : bcd_next(time_reg.year);
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            time_reg <= `TIME_RESET;
        end else begin
            time_reg <= time_next;
        end
    end

    assign time_o = time_reg;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    AST_HOURS_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick_i && !load_i && time_reg.hours == 8'h23 && time_reg.minutes == 8'h59
         && time_reg.seconds == 8'h59) |=> (time_reg.hours == 8'h00))
        else $error("hours did not wrap to 00 after 23:59:59");

    AST_FEB_LEAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick_i && !load_i && time_reg.month == 8'h02 && time_reg.date == 8'h28
         && time_reg.hours == 8'h23 && time_reg.minutes == 8'h59 && time_reg.seconds == 8'h59)
        |=> (time_reg.date == (is_leap(time_reg.year) ? 8'h29 : 8'h01)))
        else $error("February end handled wrongly");

endmodule // calendar_counter
`default_nettype wire

// file: hdl/timekeeping_sram_access.sv
// Purpose: Byte-wide retained memory with a calendar clock image on top
// Assumes: Host pins synchronous to clk_sys_i; supply monitor gives levels
// Notes:   Read data appears one cycle after address and selects
`timescale 1ns/10ps
`default_nettype none
`include "tk_defs.svh"

module timekeeping_sram_access #(
    parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic              clk_sys_i,              // System clock
    input  wire logic              reset_n_i,              // Async reset, active low
    input  wire logic [`ADDR_W-1:0] byte_addr_i,           // Byte address
    input  wire logic [`DATA_W-1:0] data_io_i,             // Data bus in
    output var  logic [`DATA_W-1:0] data_io_o,             // Data bus out
    output logic                   data_io_oe_o,           // Data bus drive enable
    input  wire logic              chip_sel_n_i,           // Chip select, active low
    input  wire logic              out_en_n_i,             // Output enable, active low
    input  wire logic              store_n_i,              // Store strobe, active low
    input  wire logic              supply_ok_i,            // Supply within tolerance
    input  wire logic              battery_switch_level_i, // Supply below switchover
    output var  logic              battery_mode_o,         // Running on battery
    output logic                   standby_o               // Deselected or protected
);
    import tk_pkg::*;

    localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

    // -------------------------------------------------------------
    // Reset synchroniser
    // -------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // -------------------------------------------------------------
    // Host cycle tracking
    // -------------------------------------------------------------
    bus_state_t           bus_state_reg;
    bus_state_t           bus_state_next;
    logic [`ADDR_W-1:0]   wr_addr_reg;
    logic [`ADDR_W-1:0]   wr_addr_next;
    logic [`DATA_W-1:0]   wr_data_reg;
    logic [`DATA_W-1:0]   wr_data_next;
    logic                 commit;
    logic                 selected;
    logic                 wr_top;

    function automatic logic in_image(input logic [`ADDR_W-1:0] a);
        in_image = (a[`ADDR_W-1:3] == `IMAGE_TAG);
    endfunction

    assign selected = !chip_sel_n_i && supply_ok_i;

    always_comb begin
        bus_state_next = bus_state_reg;
        wr_addr_next   = wr_addr_reg;
        wr_data_next   = wr_data_reg;
        commit         = 1'b0;
        case (bus_state_reg)
            BUS_IDLE, BUS_READ: begin
                if (selected && !store_n_i) begin
                    bus_state_next = BUS_WRITE;
                    wr_addr_next   = byte_addr_i;
                    wr_data_next   = data_io_i;
                end else if (selected) begin
                    bus_state_next = BUS_READ;
                end else begin
                    bus_state_next = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (!supply_ok_i) begin
                    bus_state_next = BUS_ABORT;
                end else if (chip_sel_n_i || store_n_i) begin
                    commit         = 1'b1;
                    bus_state_next = chip_sel_n_i ? BUS_IDLE : BUS_READ;
                end else begin
                    wr_addr_next = byte_addr_i;
                    wr_data_next = data_io_i;
                end
            end
            BUS_ABORT: begin
                if (chip_sel_n_i || store_n_i) begin
                    bus_state_next = BUS_IDLE;
                end
            end
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= BUS_IDLE;
            wr_addr_reg   <= '0;
            wr_data_reg   <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            wr_addr_reg   <= wr_addr_next;
            wr_data_reg   <= wr_data_next;
        end
    end

    assign wr_top = in_image(wr_addr_reg);

    // -------------------------------------------------------------
    // Storage array, retained, no reset
    // -------------------------------------------------------------
    logic [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];

    always_ff @(posedge clk_sys_i) begin
        if (commit && !wr_top) begin
            mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    // -------------------------------------------------------------
    // Clock image and control byte
    // -------------------------------------------------------------
    logic [7:0][7:0] image_reg;
    logic [7:0][7:0] image_next;
    logic            halted;
    logic            halted_q_reg;
    logic            tick_q_reg;
    logic            stopped;
    logic            tick;
    logic            update_now;
    logic            load_now;
    cal_time_t       cur_time;
    cal_time_t       load_time;

    assign halted  = image_reg[`IDX_CTRL][`CTRL_WRITE_BIT] || image_reg[`IDX_CTRL][`CTRL_READ_BIT];
    assign stopped = image_reg[`IDX_SECONDS][`SEC_STOP_BIT];
    // Copy one cycle after the tick, once the counters have advanced
    assign update_now = tick_q_reg && !halted;
    assign load_now = commit && wr_addr_reg == `CTRL_ADDR
                      && image_reg[`IDX_CTRL][`CTRL_WRITE_BIT] && !wr_data_reg[`CTRL_WRITE_BIT];

    always_comb begin
        load_time.year    = image_reg[`IDX_YEAR];
        load_time.month   = image_reg[`IDX_MONTH];
        load_time.date    = image_reg[`IDX_DATE];
        load_time.day     = image_reg[`IDX_DAY];
        load_time.hours   = image_reg[`IDX_HOURS];
        load_time.minutes = image_reg[`IDX_MINUTES];
        load_time.seconds = {1'b0, image_reg[`IDX_SECONDS][6:0]};
    end

    always_comb begin
        image_next = image_reg;
        if (update_now) begin
            image_next[`IDX_SECONDS] = {image_reg[`IDX_SECONDS][`SEC_STOP_BIT], cur_time.seconds[6:0]};
            image_next[`IDX_MINUTES] = cur_time.minutes;
            image_next[`IDX_HOURS]   = cur_time.hours;
            image_next[`IDX_DAY]     = cur_time.day;
            image_next[`IDX_DATE]    = cur_time.date;
            image_next[`IDX_MONTH]   = cur_time.month;
            image_next[`IDX_YEAR]    = cur_time.year;
        end
        if (commit && wr_top) begin
            image_next[wr_addr_reg[2:0]] = wr_data_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            image_reg    <= `IMAGE_RESET;
            halted_q_reg <= 1'b0;
            tick_q_reg   <= 1'b0;
        end else begin
            image_reg    <= image_next;
            halted_q_reg <= halted;
            tick_q_reg   <= tick;
        end
    end

    // -------------------------------------------------------------
    // One-second timer
    // -------------------------------------------------------------
    logic [24:0] tick_cnt_reg;
    logic [24:0] tick_cnt_next;

    always_comb begin
        tick          = 1'b0;
        tick_cnt_next = tick_cnt_reg + 25'h0000001;
        if (stopped || (halted_q_reg && !halted) || load_now) begin
            tick_cnt_next = '0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_next = '0;
            tick          = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Counters run regardless of supply state
    calendar_counter u_calendar (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n),
        .tick_i      (tick),
        .load_i      (load_now),
        .load_time_i (load_time),
        .time_o      (cur_time)
    );

    // -------------------------------------------------------------
    // Read path and pin outputs
    // -------------------------------------------------------------
    logic [`DATA_W-1:0] rd_data_next;
    logic               battery_next;

    always_comb begin
        rd_data_next = in_image(byte_addr_i) ? image_reg[byte_addr_i[2:0]] : mem[byte_addr_i];
        battery_next = battery_switch_level_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            data_io_o      <= '0;
            battery_mode_o <= 1'b0;
        end else begin
            data_io_o      <= rd_data_next;
            battery_mode_o <= battery_next;
        end
    end

    // Strobe low floats the bus to avoid contention during writes
    assign data_io_oe_o = selected && !out_en_n_i && store_n_i && bus_state_reg == BUS_READ;
    assign standby_o    = !selected;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    AST_OE_NEEDS_SELECTS: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        data_io_oe_o |-> (!chip_sel_n_i && !out_en_n_i))
        else $error("data bus driven without select and output enable");

    AST_DESELECT_FLOATS: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        chip_sel_n_i |-> (!data_io_oe_o && standby_o))
        else $error("bus driven or active while deselected");

    AST_NO_PROTECTED_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        commit |-> (supply_ok_i && $past(supply_ok_i)))
        else $error("write committed while supply out of tolerance");

    AST_ABORT_DROPS: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (bus_state_reg == BUS_WRITE && !supply_ok_i) |=> (bus_state_reg == BUS_ABORT && !commit))
        else $error("write not aborted on supply loss");

    AST_WRITE_END_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        commit |-> (!$past(chip_sel_n_i) && !$past(store_n_i) && (chip_sel_n_i || store_n_i)))
        else $error("write committed before select or strobe rose");

    AST_CTRL_READBACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (byte_addr_i == `CTRL_ADDR && !chip_sel_n_i) |=> (data_io_o == $past(image_reg[`IDX_CTRL])))
        else $error("control byte read back wrong");

    AST_FREEZE_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (halted && !commit) |=> (image_reg[7:1] == $past(image_reg[7:1])))
        else $error("image changed while frozen");

    AST_UPDATE_COPIES: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (update_now && !commit) |=> (image_reg[`IDX_MINUTES] == $past(cur_time.minutes)
                                     && image_reg[`IDX_YEAR] == $past(cur_time.year)))
        else $error("image not refreshed from counters");

    AST_TICK_SPACING: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        tick |-> (tick_cnt_reg == TICK_LAST && !stopped))
        else $error("second tick at wrong count");

    AST_LOAD_ON_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        load_now |=> (!image_reg[`IDX_CTRL][`CTRL_WRITE_BIT] && cur_time.hours == $past(image_reg[`IDX_HOURS])))
        else $error("counters not loaded when write bit cleared");

endmodule // timekeeping_sram_access
`default_nettype wire

// file: testbench/host_bus_model.sv
// Purpose: Host model driving the parallel memory bus of the block
// Assumes: Block samples every bus pin on the rising clock edge
// Notes:   A released data bus shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
`include "tk_defs.svh"

module host_bus_model (
    input  wire logic               clk_sys_i,  // System clock
    input  wire logic [`DATA_W-1:0] dut_data_i, // Block read data
    input  wire logic               dut_oe_i,   // Block drives bus
    output logic [`ADDR_W-1:0]      addr_o,     // Byte address
    output logic [`DATA_W-1:0]      bus_o,      // Resolved data bus
    output logic                    sel_n_o,    // Chip select
    output logic                    oe_n_o,     // Output enable
    output logic                    store_n_o   // Store strobe
);
    logic               drive = 1'b0;
    logic [`DATA_W-1:0] wdata = 8'h00;
    logic [`DATA_W-1:0] last  = 8'h00;

    initial begin
        addr_o    = '0;
        sel_n_o   = 1'b1;
        oe_n_o    = 1'b1;
        store_n_o = 1'b1;
    end

    always_ff @(posedge clk_sys_i) begin
        last <= bus_o;
    end
    always_comb bus_o = drive ? wdata : (dut_oe_i ? dut_data_i : ~last);

    // Write: strobes held low two edges, address and data held past the rising edge
    task automatic bus_write(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d, input logic oe_n);
        @(posedge clk_sys_i);
        addr_o    <= a;
        wdata     <= d;
        drive     <= 1'b1;
        oe_n_o    <= oe_n;
        sel_n_o   <= 1'b0;
        store_n_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        sel_n_o   <= 1'b1;
        store_n_o <= 1'b1;
        oe_n_o    <= 1'b1;
        @(posedge clk_sys_i);
        drive     <= 1'b0;
    endtask

    task automatic bus_read(input logic [`ADDR_W-1:0] a, input logic oe_n, input logic sel_n,
                            output logic [`DATA_W-1:0] d, output logic oe);
        @(posedge clk_sys_i);
        addr_o  <= a;
        oe_n_o  <= oe_n;
        sel_n_o <= sel_n;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        d  = dut_data_i;
        oe = dut_oe_i;
        @(posedge clk_sys_i);
        sel_n_o <= 1'b1;
        oe_n_o  <= 1'b1;
    endtask
endmodule // host_bus_model
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the timekeeping memory block
// Assumes: Tick shortened to 20 clock cycles
// Notes:   Host cycles come from the host bus model
`timescale 1ns/10ps
`default_nettype none
`include "tk_defs.svh"

module tb_top;
    localparam int unsigned TICKS = 20;
    logic               clk_sys_i;
    logic               reset_n_i;
    logic               supply_ok_i;
    logic               battery_switch_level_i;
    logic [`ADDR_W-1:0] byte_addr_i;
    logic [`DATA_W-1:0] data_io_i;
    logic [`DATA_W-1:0] data_io_o;
    logic               data_io_oe_o;
    logic               chip_sel_n_i;
    logic               out_en_n_i;
    logic               store_n_i;
    logic               battery_mode_o;
    logic               standby_o;
    logic [`DATA_W-1:0] rd;
    logic               rd_oe;
    int                 n_errors = 0;
    int                 checks = 0;

    timekeeping_sram_access #(.TICK_CYCLES(TICKS)) u_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .byte_addr_i(byte_addr_i),
        .data_io_i(data_io_i), .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o),
        .chip_sel_n_i(chip_sel_n_i), .out_en_n_i(out_en_n_i), .store_n_i(store_n_i),
        .supply_ok_i(supply_ok_i), .battery_switch_level_i(battery_switch_level_i),
        .battery_mode_o(battery_mode_o), .standby_o(standby_o));

    host_bus_model u_host (
        .clk_sys_i(clk_sys_i), .dut_data_i(data_io_o), .dut_oe_i(data_io_oe_o),
        .addr_o(byte_addr_i), .bus_o(data_io_i), .sel_n_o(chip_sel_n_i),
        .oe_n_o(out_en_n_i), .store_n_o(store_n_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [7:0] exp);
        u_host.bus_read(a, 1'b0, 1'b0, rd, rd_oe);
        check($sformatf("byte %h", a), rd, exp);
        check("bus drive", {7'h00, rd_oe}, 8'h01);
    endtask

    task automatic t_memory;
        logic [`ADDR_W-1:0] ad [5] = '{19'h00000, 19'h00001, 19'h7FFF7, 19'h3FFF7, 19'h55AA3};
        logic [7:0]         dv [5] = '{8'hA5, 8'h5A, 8'hFF, 8'h00, 8'h3C};
        for (int i = 0; i < 5; i++) u_host.bus_write(ad[i], dv[i], 1'(i % 2));
        for (int i = 0; i < 5; i++) rd_chk(ad[i], dv[i]);
    endtask

    task automatic t_output_enable;
        u_host.bus_read(19'h00000, 1'b1, 1'b0, rd, rd_oe);
        check("oe high drive", {7'h00, rd_oe}, 8'h00);
        check("oe high data", rd, 8'hA5);
        u_host.bus_read(19'h00000, 1'b0, 1'b1, rd, rd_oe);
        check("deselect drive", {7'h00, rd_oe}, 8'h00);
        check("deselect standby", {7'h00, standby_o}, 8'h01);
    endtask

    task automatic t_supply;
        @(posedge clk_sys_i);
        supply_ok_i <= 1'b0;
        battery_switch_level_i <= 1'b1;
        u_host.bus_write(19'h00000, 8'hC3, 1'b1);
        check("battery mode", {7'h00, battery_mode_o}, 8'h01);
        fork
            u_host.bus_read(19'h00000, 1'b0, 1'b0, rd, rd_oe);
            begin
                repeat (2) @(negedge clk_sys_i);
                check("protect standby", {7'h00, standby_o}, 8'h01);
            end
        join
        check("protect drive", {7'h00, rd_oe}, 8'h00);
        @(posedge clk_sys_i);
        supply_ok_i <= 1'b1;
        battery_switch_level_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check("main mode", {7'h00, battery_mode_o}, 8'h00);
        rd_chk(19'h00000, 8'hA5);
        fork
            u_host.bus_write(19'h00000, 8'h99, 1'b1);
            begin
                repeat (2) @(posedge clk_sys_i);
                supply_ok_i <= 1'b0;
            end
        join
        @(posedge clk_sys_i);
        supply_ok_i <= 1'b1;
        rd_chk(19'h00000, 8'hA5);
    endtask

    task automatic t_stop;
        u_host.bus_write(`CTRL_ADDR, 8'h00, 1'b1);
        u_host.bus_write(`CTRL_ADDR | 19'h00001, 8'h80, 1'b1);
        repeat (2 * TICKS) @(posedge clk_sys_i);
        rd_chk(`CTRL_ADDR | 19'h00001, 8'h80);
    endtask

    task automatic t_calendar(input logic [7:0] d, m, y, ed, em, ey);
        logic [7:0] img [8];
        logic [7:0] exp [8];
        img = '{8'h80, 8'h59, 8'h59, 8'h23, 8'h07, d, m, y};
        exp = '{8'h45, 8'h00, 8'h00, 8'h00, 8'h01, ed, em, ey};
        for (int i = 0; i < 8; i++) u_host.bus_write(`CTRL_ADDR | 19'(i), img[i], 1'b1);
        u_host.bus_write(`CTRL_ADDR, 8'h00, 1'b1);
        repeat (TICKS + 5) @(posedge clk_sys_i);
        u_host.bus_write(`CTRL_ADDR, 8'h45, 1'b1);
        repeat (2 * TICKS) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) rd_chk(`CTRL_ADDR | 19'(i), exp[i]);
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        n_errors++;
        wrap_up();
    end

    initial begin
        reset_n_i = 1'b0;
        supply_ok_i = 1'b1;
        battery_switch_level_i = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd_chk(`CTRL_ADDR, 8'h00);
        rd_chk(19'h7FFFC, 8'h01);
        t_memory();
        t_output_enable();
        t_supply();
        t_calendar(8'h28, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01);
        t_calendar(8'h28, 8'h02, 8'h04, 8'h29, 8'h02, 8'h04);
        t_calendar(8'h30, 8'h04, 8'h05, 8'h01, 8'h05, 8'h05);
        t_calendar(8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00);
        t_stop();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
